// file: rtl/cwg_top.sv
// Eight-channel compare-match waveform generator with its base timer.
// Assumes base_count_clock is a one-cycle count tick made on clk and
// an Avalon-MM master that holds each request until waitrequest is low.
`timescale 1ns/1ps

// Notes on behaviour
// - Three output modes per channel, chosen by field
// - Single-phase: high on match, low at zero
// - Initial level bit sets starting output level
// - Polarity flip inverts waveform at the pin
// - Free-run single-phase: period 65536, high 65536-m
// - Period reset: period n+2, high n+2-m
// - Waveform function plus enable starts; clear stops
// - Match on compare value sets match flag
// - Phase-delayed: toggle output on every match
// - Free-run phase-delayed: high and low 65536 each
// - Period reset: halves n+2; large compare never toggles
// - Set/reset: even sets, odd or zero clears
// - Free-run set/reset widths follow m and n
// - Period-reset set/reset widths follow m, n, p+2
// - Odd clear match raises odd flag too
// - Reload timing picks when compare value loads
// - Channel 0 single-phase when it resets timer; here channel 0 keeps its own mode field
// - Timer clears after matching channel 0 value
module cwg_top (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          ce,
    input  wire logic                          base_count_clock,
    input  wire cwg_pkg::cwg_avs_req_t         avs_req,
    output cwg_pkg::cwg_avs_rsp_t              avs_rsp,
    output logic [cwg_pkg::CH_N-1:0]           pulse_output_pin,
    output logic [cwg_pkg::CH_N-1:0]           match_irq_flag
);
    localparam int N  = cwg_pkg::CH_N;
    localparam int TW = cwg_pkg::TW;
    localparam int DW = cwg_pkg::DW;
    localparam int CW = cwg_pkg::CTL_W;
    localparam int BW = cwg_pkg::BTC_W;

    typedef struct packed {
        logic [BW-1:0]        base_timer_control;
        logic [TW-1:0]        timer;
        logic [N-1:0]         function_select_reg;
        logic [N-1:0]         channel_enable_reg;
        logic [N-1:0]         flag;
        logic [N-1:0]         level;
        logic [N-1:0]         pin;
        logic [N-1:0][CW-1:0] channel_output_control;
        cwg_pkg::cwg_avs_rsp_t rsp;
    } cwg_top_st_t;

    cwg_top_st_t st;
    cwg_top_st_t next_st;

    logic                 req;
    logic                 acc_wr;
    logic [2:0]           bank;
    logic [2:0]           idx;
    logic [N-1:0]         wr_cmp;
    logic [N-1:0]         match;
    logic [N-1:0]         active;
    logic [N-1:0][TW-1:0] cmp_buf;
    logic [N-1:0][TW-1:0] cmp_act;
    logic                 run;
    logic                 tick;
    logic                 at_zero;
    logic                 period_rst;
    logic                 period_hit;
    logic                 reload_evt;
    logic [DW-1:0]        rd_word;

    assign req    = avs_req.read | avs_req.write;
    // Writes land on the edge where the master sees waitrequest low
    assign acc_wr = avs_req.write & ~st.rsp.waitrequest;
    assign bank   = avs_req.address[cwg_pkg::BANK_LSB +: 3];
    assign idx    = avs_req.address[cwg_pkg::IDX_LSB +: 3];

    assign run        = st.base_timer_control[cwg_pkg::BTC_RUN];
    assign tick       = run & base_count_clock;
    assign at_zero    = (st.timer == cwg_pkg::TMR_ZERO);
    // Other reset sources live outside; high source bit masks this one
    assign period_rst = st.base_timer_control[cwg_pkg::BTC_PRST]
                      & ~st.base_timer_control[cwg_pkg::BTC_RHI];
    // Clear two counts after the match, so the period is n+2
    assign period_hit = period_rst
                      & (st.timer == cmp_act[0] + cwg_pkg::TMR_ONE);
    assign reload_evt = tick & at_zero;

    // Waveform function selected and enabled
    assign active = st.channel_enable_reg & ~st.function_select_reg;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            assign wr_cmp[g] = acc_wr
                & (bank == cwg_pkg::OFF_CMP[cwg_pkg::BANK_LSB +: 3])
                & (idx == 3'(g));
            cwg_chan u_chan (
                .clk        (clk),
                .sys_rst    (sys_rst),
                .ce         (ce),
                .wr_stb     (wr_cmp[g]),
                .wr_data    (avs_req.writedata[TW-1:0]),
                .reload_sel (st.channel_output_control[g][cwg_pkg::CTL_RLD]),
                .reload_evt (reload_evt),
                .timer      (st.timer),
                .match      (match[g]),
                .cmp_buf    (cmp_buf[g]),
                .cmp_act    (cmp_act[g])
            );
        end
    endgenerate

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_word = '0;
        if (bank == cwg_pkg::OFF_CMP[cwg_pkg::BANK_LSB +: 3]) begin
            rd_word[TW-1:0] = cmp_buf[idx];
        end else if (bank == cwg_pkg::OFF_CTL[cwg_pkg::BANK_LSB +: 3]) begin
            rd_word[CW-1:0] = st.channel_output_control[idx];
        end else if (bank == cwg_pkg::OFF_ACT[cwg_pkg::BANK_LSB +: 3]) begin
            rd_word[TW-1:0] = cmp_act[idx];
        end else begin
            case (avs_req.address)
                cwg_pkg::OFF_BTC: begin
                    rd_word[BW-1:0] = st.base_timer_control;
                end
                cwg_pkg::OFF_TMR: begin
                    rd_word[TW-1:0] = st.timer;
                end
                cwg_pkg::OFF_FSEL: begin
                    rd_word[N-1:0] = st.function_select_reg;
                end
                cwg_pkg::OFF_ENA: begin
                    rd_word[N-1:0] = st.channel_enable_reg;
                end
                cwg_pkg::OFF_FLAG: begin
                    rd_word[N-1:0] = st.flag;
                end
                cwg_pkg::OFF_PIN: begin
                    rd_word[N-1:0] = st.pin;
                end
                default: begin
                    rd_word = '0;
                end
            endcase
        end
    end

    always_comb begin
        logic [N-1:0]      set_flag;
        logic [N-1:0]      clr_flag;
        logic              timer_wr;
        logic              lvl;
        logic              sr_even;
        logic              clr_sr;
        cwg_pkg::cwg_mode_t mode;
        set_flag = '0;
        clr_flag = '0;
        timer_wr = 1'b0;
        lvl      = 1'b0;
        sr_even  = 1'b0;
        clr_sr   = 1'b0;
        mode     = cwg_pkg::CWG_SINGLE;
        next_st  = st;

        // Bus handshake: one wait state, read data caught beforehand
        if (req && st.rsp.waitrequest) begin
            next_st.rsp.waitrequest = 1'b0;
            next_st.rsp.readdata    = avs_req.read ? rd_word : '0;
        end else begin
            next_st.rsp.waitrequest = 1'b1;
        end

        if (acc_wr) begin
            case (avs_req.address)
                cwg_pkg::OFF_BTC: begin
                    next_st.base_timer_control = avs_req.writedata[BW-1:0];
                end
                cwg_pkg::OFF_TMR: begin
                    timer_wr = run;
                end
                cwg_pkg::OFF_FSEL: begin
                    next_st.function_select_reg = avs_req.writedata[N-1:0];
                end
                cwg_pkg::OFF_ENA: begin
                    next_st.channel_enable_reg = avs_req.writedata[N-1:0];
                end
                cwg_pkg::OFF_FLAG: begin
                    clr_flag = avs_req.writedata[N-1:0];
                end
                default: begin
                    clr_flag = '0;
                end
            endcase
            if (bank == cwg_pkg::OFF_CTL[cwg_pkg::BANK_LSB +: 3]) begin
                next_st.channel_output_control[idx] =
                    avs_req.writedata[CW-1:0];
            end
        end

        // Base timer; a stopped timer sits at zero and ignores writes
        if (!run) begin
            next_st.timer = cwg_pkg::TMR_ZERO;
        end else if (timer_wr) begin
            next_st.timer = avs_req.writedata[TW-1:0];
        end else if (tick && period_hit) begin
            next_st.timer = cwg_pkg::TMR_ZERO;
        end else if (tick) begin
            next_st.timer = st.timer + cwg_pkg::TMR_ONE;
        end

        for (int i = 0; i < N; i++) begin
            mode = cwg_pkg::cwg_mode_t'(
                st.channel_output_control[i][cwg_pkg::CTL_MODE +: 3]);
            lvl = st.level[i];
            if (!active[i]) begin
                // Idle channel rests at its starting level
                lvl = st.channel_output_control[i][cwg_pkg::CTL_IVL];
            end else if (tick) begin
                // Flag on every own match in every mode
                set_flag[i] = match[i];
                unique case (mode)
                    cwg_pkg::CWG_SINGLE: begin
                        // Set beats zero, so m=0 stays high
                        if (match[i]) begin
                            lvl = 1'b1;
                        end else if (at_zero) begin
                            lvl = 1'b0;
                        end
                    end
                    cwg_pkg::CWG_PHASE: begin
                        // Unreached values never toggle
                        if (match[i]) begin
                            lvl = ~st.level[i];
                        end
                    end
                    cwg_pkg::CWG_SR: begin
                        // Odd partner only supplies the clear value
                        if (i % 2 == 0) begin
                            clr_sr = match[i + 1] | at_zero;
                            if (match[i]) begin
                                lvl = 1'b1;
                            end else if (clr_sr) begin
                                lvl = 1'b0;
                            end
                        end
                    end
                    default: begin
                        lvl = st.level[i];
                    end
                endcase
            end
            next_st.level[i] = lvl;
            // Flip after the waveform so widths swap
            next_st.pin[i] = lvl
                ^ st.channel_output_control[i][cwg_pkg::CTL_INV];
        end

        // Odd clear match flags the odd channel whenever its even partner is active in set/reset mode
        for (int i = 0; i < N; i += 2) begin
            sr_even = active[i] & (cwg_pkg::cwg_mode_t'(
                st.channel_output_control[i][cwg_pkg::CTL_MODE +: 3])
                == cwg_pkg::CWG_SR);
            if (sr_even && tick && match[i + 1]) begin
                set_flag[i + 1] = 1'b1;
            end
        end

        // A match in the clearing cycle is kept
        next_st.flag = (st.flag & ~clr_flag) | set_flag;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st.base_timer_control     <= cwg_pkg::BTC_RST;
            st.timer                  <= cwg_pkg::TMR_ZERO;
            st.function_select_reg    <= cwg_pkg::CH_RST;
            st.channel_enable_reg     <= cwg_pkg::CH_RST;
            st.flag                   <= cwg_pkg::CH_RST;
            st.level                  <= cwg_pkg::CH_RST;
            st.pin                    <= cwg_pkg::CH_RST;
            st.channel_output_control <= '{default: cwg_pkg::CTL_RST};
            st.rsp.readdata           <= '0;
            st.rsp.waitrequest        <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign avs_rsp          = st.rsp;
    assign pulse_output_pin = st.pin;
    assign match_irq_flag   = st.flag;
endmodule

// file: shared/cwg_pkg.sv
// Shared constants and carriers of the compare waveform generator.
// Assumes a 32-bit Avalon-MM slave port and a 40 MHz clk.
package cwg_pkg;
    localparam int CH_N = 8;
    localparam int TW   = 16;
    localparam int AW   = 8;
    localparam int DW   = 32;
    localparam int IW   = 3;

    typedef struct packed {
        logic          read;
        logic          write;
        logic [AW-1:0] address;
        logic [DW-1:0] writedata;
    } cwg_avs_req_t;

    typedef struct packed {
        logic [DW-1:0] readdata;
        logic          waitrequest;
    } cwg_avs_rsp_t;

    // Byte offsets of aligned words; CMP, CTL and ACT each start a bank of eight words
    localparam logic [AW-1:0] OFF_BTC   = 8'h00;
    localparam logic [AW-1:0] OFF_TMR   = 8'h04;
    localparam logic [AW-1:0] OFF_FSEL  = 8'h08;
    localparam logic [AW-1:0] OFF_ENA   = 8'h0C;
    localparam logic [AW-1:0] OFF_FLAG  = 8'h10;
    localparam logic [AW-1:0] OFF_PIN   = 8'h14;
    localparam logic [AW-1:0] OFF_CMP   = 8'h20;
    localparam logic [AW-1:0] OFF_CTL   = 8'h40;
    localparam logic [AW-1:0] OFF_ACT   = 8'h60;
    localparam int            BANK_LSB  = 5;
    localparam int            IDX_LSB   = 2;

    // Base timer control fields
    localparam int            BTC_RUN   = 0;
    localparam int            BTC_PRST  = 1;
    localparam int            BTC_RHI   = 2;
    localparam int            BTC_W     = 3;
    localparam logic [BTC_W-1:0] BTC_RST = 3'h0;

    // Channel output control fields
    localparam int            CTL_MODE  = 0;
    localparam int            CTL_IVL   = 3;
    localparam int            CTL_RLD   = 4;
    localparam int            CTL_INV   = 5;
    localparam int            CTL_W     = 6;
    localparam logic [CTL_W-1:0] CTL_RST = 6'h00;

    localparam logic [TW-1:0] TMR_ZERO  = 16'h0000;
    localparam logic [TW-1:0] TMR_ONE   = 16'h0001;
    localparam logic [TW-1:0] CMP_RST   = 16'h0000;
    localparam logic [CH_N-1:0] CH_RST  = 8'h00;

    typedef enum logic [2:0] {
        CWG_SINGLE = 3'h0,
        CWG_PHASE  = 3'h1,
        CWG_SR     = 3'h2
    } cwg_mode_t;
endpackage

// file: rtl/cwg_chan.sv
// One channel's compare store: written value and active compare value.
// Assumes strobes come from logic on clk; reload_evt marks timer zero.
`timescale 1ns/1ps
module cwg_chan (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   ce,
    input  wire logic                   wr_stb,
    input  wire logic [cwg_pkg::TW-1:0] wr_data,
    input  wire logic                   reload_sel,
    input  wire logic                   reload_evt,
    input  wire logic [cwg_pkg::TW-1:0] timer,
    output logic                        match,
    output logic [cwg_pkg::TW-1:0]      cmp_buf,
    output logic [cwg_pkg::TW-1:0]      cmp_act
);
    typedef struct packed {
        logic [cwg_pkg::TW-1:0] held;
        logic [cwg_pkg::TW-1:0] act;
    } cwg_chan_st_t;

    cwg_chan_st_t st;
    cwg_chan_st_t next_st;

    always_comb begin
        next_st = st;
        if (wr_stb) begin
            next_st.held = wr_data;
        end
        // Deferred values wait for the timer to pass zero
        if (!reload_sel && wr_stb) begin
            next_st.act = wr_data;
        end else if (reload_sel && reload_evt) begin
            next_st.act = st.held;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{held: cwg_pkg::CMP_RST, act: cwg_pkg::CMP_RST};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign match   = (st.act == timer);
    assign cmp_buf = st.held;
    assign cmp_act = st.act;
endmodule

// file: verif/cwg_chk.sv
// Port-level checker of the compare waveform generator top.
// Assumes a bind onto cwg_top and ce lowered only while the bus is idle.
`timescale 1ns/1ps
module cwg_chk (
    input wire logic                     clk,
    input wire logic                     sys_rst,
    input wire logic                     ce,
    input wire logic                     base_count_clock,
    input wire cwg_pkg::cwg_avs_req_t    avs_req,
    input wire cwg_pkg::cwg_avs_rsp_t    avs_rsp,
    input wire logic [cwg_pkg::CH_N-1:0] pulse_output_pin,
    input wire logic [cwg_pkg::CH_N-1:0] match_irq_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       wr_go;
    logic [7:0] en_q;
    logic [7:0] en_d;
    logic [7:0] en_a;
    logic [7:0] act;
    assign wr_go = avs_req.write && !avs_rsp.waitrequest;
    // Old and new enable both count: the write edge is ambiguous
    assign en_a = en_q | en_d;
    assign act = en_a | ({en_a[6:0], 1'b0} & 8'hAA);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q <= 8'h00;
            en_d <= 8'h00;
        end else if (ce) begin
            en_d <= en_q;
            if (wr_go && avs_req.address == cwg_pkg::OFF_ENA) begin
                en_q <= avs_req.writedata[7:0];
            end
        end
    end
    sequence s_rd(logic [7:0] a);
        avs_req.read && !avs_rsp.waitrequest && avs_req.address == a;
    endsequence
    sequence s_req_new;
        (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
    endsequence
    a_wait_pulse:
        assert property ($fell(avs_rsp.waitrequest) |=> avs_rsp.waitrequest)
        else $error("waitrequest low too long");
    a_wait_answer:
        assert property (s_req_new |=> !avs_rsp.waitrequest)
        else $error("no answer after one cycle");
    a_flag_tick:
        assert property (|(match_irq_flag & ~$past(match_irq_flag))
            |-> $past(base_count_clock)) else $error("flag without tick");
    a_flag_idle:
        assert property ((match_irq_flag & ~$past(match_irq_flag) & ~act)
            == 8'h00) else $error("flag on idle channel");
    a_flag_clear:
        assert property (|(~match_irq_flag & $past(match_irq_flag)) |->
            $past(wr_go) && $past(avs_req.address) == cwg_pkg::OFF_FLAG)
        else $error("flag dropped without clear");
    a_pin_cause:
        assert property (pulse_output_pin != $past(pulse_output_pin) |->
            $past(base_count_clock) || $past(wr_go, 2))
        else $error("pin moved without cause");
    a_pin_read:
        assert property (s_rd(cwg_pkg::OFF_PIN) |-> avs_rsp.readdata ==
            {24'h000000, $past(pulse_output_pin)}) else $error("pin readback");
    a_void_read:
        assert property (avs_req.read && !avs_rsp.waitrequest &&
            avs_req.address[7] |-> avs_rsp.readdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule

bind cwg_top cwg_chk i_cwg_chk (
    .clk(clk), .sys_rst(sys_rst), .ce(ce),
    .base_count_clock(base_count_clock),
    .avs_req(avs_req), .avs_rsp(avs_rsp),
    .pulse_output_pin(pulse_output_pin), .match_irq_flag(match_irq_flag)
);

// file: verif/tb_top.sv
// Self-checking bench of the compare waveform generator top.
// Assumes the checker is bound in; ticks stay high while widths are timed.
`timescale 1ns/1ps
module tb_top;
    logic                  clk;
    logic                  sys_rst = 1'b1;
    logic                  bcc = 1'b0;
    logic                  ce = 1'b1;
    cwg_pkg::cwg_avs_req_t req = '0;
    cwg_pkg::cwg_avs_rsp_t rsp;
    logic [7:0]            pin;
    logic [7:0]            flg;
    logic [31:0]           seed = 32'h3603B240;
    int                    num_errors = 0;
    int                    num_checks = 0;

    cwg_top i_cwg_top (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .base_count_clock(bcc),
        .avs_req(req), .avs_rsp(rsp), .pulse_output_pin(pin),
        .match_irq_flag(flg)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] cw(logic [2:0] md, logic iv, logic rl,
                                       logic nv);
        return {26'h0, nv, rl, iv, md};
    endfunction
    function automatic int hi_sgl(int m, int per);
        return (m >= per) ? 0 : per - m;
    endfunction
    function automatic int hi_sr(int m, int n, int per);
        return (n > m && n < per) ? n - m : per - m;
    endfunction
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Holds the request until waitrequest is seen low, then one idle edge
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] q);
        req.read <= !w;
        req.write <= w;
        req.address <= a;
        req.writedata <= d;
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    // Skips the partial phase, then counts one whole phase at level lv
    task automatic meas(int ch, logic lv, output int w);
        int i;
        w = 0;
        for (i = 0; i < 4000 && pin[ch] === lv; i++) @(posedge clk);
        for (i = 0; i < 4000 && pin[ch] !== lv; i++) @(posedge clk);
        for (i = 0; i < 4000 && pin[ch] === lv; i++) begin
            @(posedge clk);
            w++;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("[ERR] run expected end seen hang");
        close_out();
    end
    initial begin
        int n, per, w1, w2, w4, w7;
        logic [15:0] m [8];
        logic [31:0] c [8];
        logic [31:0] q;
        logic [31:0] q0;
        logic [7:0]  p0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        bcc <= 1'b1;
        @(posedge clk);
        n = 24 + int'(rnd() % 40);
        per = n + 2;
        m[0] = 16'(n);
        m[1] = 16'(1 + rnd() % (n + 1));
        m[2] = 16'(1 + rnd() % (n / 2));
        m[3] = m[2] + 16'(1 + rnd() % (n / 2));
        m[4] = 16'(rnd() % per);
        m[5] = 16'(per + rnd() % 8);
        m[6] = 16'(per + 3);
        m[7] = 16'(n + 1);
        c = '{cw(0, 0, 0, 0), cw(0, 0, 0, 0), cw(2, 0, 0, 0), cw(2, 0, 0, 0),
              cw(1, 0, 0, 0), cw(0, 0, 0, 0), cw(1, 1, 0, 0), cw(0, 0, 0, 1)};
        wr(cwg_pkg::OFF_BTC, 32'h3);
        wr(cwg_pkg::OFF_FSEL, 32'h0);
        for (int j = 0; j < 8; j++) begin
            wr(cwg_pkg::OFF_CMP + 8'(4 * j), {16'h0, m[j]});
            wr(cwg_pkg::OFF_CTL + 8'(4 * j), c[j]);
        end
        wr(cwg_pkg::OFF_ENA, 32'hF7);
        fork
            meas(1, 1'b1, w1);
            meas(2, 1'b1, w2);
            meas(4, 1'b1, w4);
            meas(7, 1'b0, w7);
        join
        chk("single high", hi_sgl(m[1], per), w1);
        chk("sr high", hi_sr(m[2], m[3], per), w2);
        chk("phase high", per, w4);
        chk("inverted low", hi_sgl(m[7], per), w7);
        chk("fixed pins", 32'h40, {24'h0, pin & 8'h60});
        rdc("flags", cwg_pkg::OFF_FLAG, 32'h9F);
        chk("flag port", 32'h9F, {24'h0, flg});
        for (int j = 0; j < 4; j++) begin
            acc(1'b0, cwg_pkg::OFF_TMR, 32'h0, q);
            chk("timer bound", 1, q < per);
        end
        // Frozen cycles must advance neither timer nor pins
        acc(1'b0, cwg_pkg::OFF_TMR, 32'h0, q0);
        ce <= 1'b0;
        @(posedge clk);
        p0 = pin;
        repeat (9) @(posedge clk);
        chk("frozen pins", {24'h0, p0}, {24'h0, pin});
        ce <= 1'b1;
        acc(1'b0, cwg_pkg::OFF_TMR, 32'h0, q);
        chk("frozen timer", (int'(q0) + 3) % per, q);
        $display("test period done");
        wr(cwg_pkg::OFF_ENA, 32'h0);
        wr(cwg_pkg::OFF_FLAG, 32'hFF);
        repeat (3 * per) begin
            bcc <= 1'(rnd() >> 7);
            @(posedge clk);
        end
        bcc <= 1'b1;
        rdc("idle flags", cwg_pkg::OFF_FLAG, 32'h0);
        rdc("idle pins", cwg_pkg::OFF_PIN, 32'hC0);
        chk("idle pin port", 32'hC0, {24'h0, pin});
        rdc("unmapped", 8'hFC, 32'h0);
        $display("test idle done");
        for (int j = 1; j < 4; j++) begin
            m[j] = 16'hFF00 | 16'(rnd() & 32'hFF);
        end
        wr(cwg_pkg::OFF_BTC, 32'h1);
        for (int j = 1; j < 4; j++) begin
            wr(cwg_pkg::OFF_CMP + 8'(4 * j), {16'h0, m[j]});
        end
        wr(cwg_pkg::OFF_CTL + 8'h14, cw(0, 0, 1, 0));
        wr(cwg_pkg::OFF_CMP + 8'h14, 32'h0100);
        rdc("held cmp", cwg_pkg::OFF_ACT + 8'h14, {16'h0, m[5]});
        wr(cwg_pkg::OFF_ENA, 32'h26);
        wr(cwg_pkg::OFF_TMR, 32'hFEF0);
        fork
            meas(1, 1'b1, w1);
            meas(2, 1'b1, w2);
        join
        chk("free single", hi_sgl(m[1], 65536), w1);
        chk("free sr", hi_sr(m[2], m[3], 65536), w2);
        rdc("loaded cmp", cwg_pkg::OFF_ACT + 8'h14, 32'h0100);
        $display("test freerun done");
        close_out();
    end
endmodule
